// >>> logic/cfg_header.sv
// PCI target configuration header registers and memory window decode
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Class field bits 31:8, default host bridge
// - Class loadable from EEPROM only
// - Read-only 8-bit revision in bits 7:0
// - Revision loadable from EEPROM
// - Refuse config-port identification access in subordinate mode
// - Self-test capable bit reads zero
// - Multi-function bit reads zero
// - Header layout default zero, EEPROM loadable
// - Writable grant loss timer bits 15:8
// - Timer low two bits forced zero
// - Writable line size, steers burst command
// - Window 0 writes bits 31:29 only
// - Window 1 writes bits 31:24 only
// - Window 2 writes bits 31:20 only
// - Windows 0 and 1 prefetchable
// - Window 2 not prefetchable
// - Type bits 2:1 read 00
// - Space indicator bit 0 reads zero
// - Windows at config offsets 10,18,20
// - Claim memory only when space enabled
module cfg_header (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Mode and command register input
    input wire logic subordinate_mode,
    input wire logic mem_space_enable,
    // EEPROM initialization load
    input wire logic eeprom_load,
    input wire logic [23:0] eeprom_device_class,
    input wire logic [7:0] eeprom_silicon_rev,
    input wire logic [6:0] eeprom_header_layout,
    // Local register port
    input wire logic loc_wr,
    input wire logic loc_rd,
    input wire logic [15:0] loc_addr,
    input wire logic [31:0] loc_wdata,
    output logic [31:0] loc_rdata,
    // Configuration space port
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_offset,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    output logic cfg_refused,
    // Memory access decode
    input wire logic mem_valid,
    input wire logic [31:0] mem_addr,
    output logic [2:0] window_hit,
    // Values used by the transaction engine
    output logic [7:0] grant_loss_timer,
    output logic [7:0] line_size
);

    ////////////////////////////////////////////////////////////////
    // Register index decode shared by both ports
    typedef enum {IDX_NONE, IDX_CLASS, IDX_CFG1, IDX_W0, IDX_W1, IDX_W2, IDX_UPPER} reg_idx_t;

    function automatic reg_idx_t decode_loc(input logic [15:0] a);
        unique case (a)
            cfg_header_pkg::ADDR_CLASS_REV: decode_loc = IDX_CLASS;
            cfg_header_pkg::ADDR_HDR_CFG1: decode_loc = IDX_CFG1;
            cfg_header_pkg::ADDR_WIN0_LOW: decode_loc = IDX_W0;
            cfg_header_pkg::ADDR_WIN1_LOW: decode_loc = IDX_W1;
            cfg_header_pkg::ADDR_WIN2: decode_loc = IDX_W2;
            cfg_header_pkg::ADDR_WIN0_HIGH: decode_loc = IDX_UPPER;
            cfg_header_pkg::ADDR_WIN1_HIGH: decode_loc = IDX_UPPER;
            default: decode_loc = IDX_NONE;
        endcase
    endfunction

    function automatic reg_idx_t decode_cfg(input logic [7:0] a);
        unique case (a)
            cfg_header_pkg::CFG_CLASS_REV: decode_cfg = IDX_CLASS;
            cfg_header_pkg::CFG_HDR_CFG1: decode_cfg = IDX_CFG1;
            cfg_header_pkg::CFG_WIN0_LOW: decode_cfg = IDX_W0;
            cfg_header_pkg::CFG_WIN1_LOW: decode_cfg = IDX_W1;
            cfg_header_pkg::CFG_WIN2: decode_cfg = IDX_W2;
            cfg_header_pkg::CFG_WIN0_HIGH: decode_cfg = IDX_UPPER;
            cfg_header_pkg::CFG_WIN1_HIGH: decode_cfg = IDX_UPPER;
            default: decode_cfg = IDX_NONE;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////
    // Stored fields
    logic [23:0] device_class;
    logic [7:0] silicon_rev;
    logic [6:0] header_layout;
    logic [5:0] timer_high;
    logic [cfg_header_pkg::WIN0_BITS-1:0] win0_base;
    logic [cfg_header_pkg::WIN1_BITS-1:0] win1_base;
    logic [cfg_header_pkg::WIN2_BITS-1:0] win2_base;

    reg_idx_t loc_idx;
    reg_idx_t cfg_idx;
    logic cfg_blocked;
    logic cfg_wr_ok;
    logic wr_any;
    reg_idx_t wr_idx;
    logic [31:0] wr_data;
    logic [31:0] loc_view;
    logic [31:0] cfg_view;

    assign loc_idx = decode_loc(loc_addr);
    assign cfg_idx = decode_cfg(cfg_offset);
    assign cfg_blocked = subordinate_mode && (cfg_idx == IDX_CLASS);
    assign cfg_wr_ok = cfg_wr && !cfg_blocked;
    // Configuration write takes priority when both ports write at once
    assign wr_any = cfg_wr_ok || loc_wr;
    assign wr_idx = cfg_wr_ok ? cfg_idx : loc_idx;
    assign wr_data = cfg_wr_ok ? cfg_wdata : loc_wdata;

    // One write strobe per writable register
    logic wr_cfg1;
    logic wr_win0;
    logic wr_win1;
    logic wr_win2;
    assign wr_cfg1 = wr_any && (wr_idx == IDX_CFG1);
    assign wr_win0 = wr_any && (wr_idx == IDX_W0);
    assign wr_win1 = wr_any && (wr_idx == IDX_W1);
    assign wr_win2 = wr_any && (wr_idx == IDX_W2);

    ////////////////////////////////////////////////////////////////
    // Identification fields: loaded only from EEPROM
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            device_class <= cfg_header_pkg::DEVICE_CLASS_RST;
        end else if (eeprom_load) begin
            device_class <= eeprom_device_class;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            silicon_rev <= cfg_header_pkg::SILICON_REV_RST;
        end else if (eeprom_load) begin
            silicon_rev <= eeprom_silicon_rev;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            header_layout <= cfg_header_pkg::HEADER_LAYOUT_RST;
        end else if (eeprom_load) begin
            header_layout <= eeprom_header_layout;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Bus writable fields, one register per block
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            timer_high <= '0;
        end else if (wr_cfg1) begin
            timer_high <= wr_data[cfg_header_pkg::TIMER_MSB:cfg_header_pkg::TIMER_LSB];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            line_size <= '0;
        end else if (wr_cfg1) begin
            line_size <= wr_data[cfg_header_pkg::LINE_MSB:cfg_header_pkg::LINE_LSB];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            win0_base <= '0;
        end else if (wr_win0) begin
            win0_base <= wr_data[cfg_header_pkg::WORD_MSB -: cfg_header_pkg::WIN0_BITS];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            win1_base <= '0;
        end else if (wr_win1) begin
            win1_base <= wr_data[cfg_header_pkg::WORD_MSB -: cfg_header_pkg::WIN1_BITS];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            win2_base <= '0;
        end else if (wr_win2) begin
            win2_base <= wr_data[cfg_header_pkg::WORD_MSB -: cfg_header_pkg::WIN2_BITS];
        end
    end

    assign grant_loss_timer = {timer_high, 2'b00} & cfg_header_pkg::GRANT_TIMER_MASK;

    ////////////////////////////////////////////////////////////////
    // Read views, one word per register
    logic [31:0] view_class;
    logic [31:0] view_cfg1;
    logic [31:0] view_win0;
    logic [31:0] view_win1;
    logic [31:0] view_win2;
    assign view_class = {device_class, silicon_rev};
    // Self-test and multi-function bits read zero
    assign view_cfg1 = {1'b0, 7'h00, 1'b0, header_layout, grant_loss_timer,
        line_size};
    assign view_win0 = {win0_base, 25'h0, cfg_header_pkg::WIN_LOW_PREF};
    assign view_win1 = {win1_base, 20'h0, cfg_header_pkg::WIN_LOW_PREF};
    assign view_win2 = {win2_base, 16'h0, cfg_header_pkg::WIN_LOW_NOPREF};

    function automatic logic [31:0] pick_view(
        input reg_idx_t idx,
        input logic [31:0] v_class,
        input logic [31:0] v_cfg1,
        input logic [31:0] v_win0,
        input logic [31:0] v_win1,
        input logic [31:0] v_win2
    );
        unique case (idx)
            IDX_CLASS: pick_view = v_class;
            IDX_CFG1: pick_view = v_cfg1;
            IDX_W0: pick_view = v_win0;
            IDX_W1: pick_view = v_win1;
            IDX_W2: pick_view = v_win2;
            default: pick_view = 32'h0;
        endcase
    endfunction

    // Views go in as arguments so the selection follows every field change
    assign loc_view = pick_view(loc_idx, view_class, view_cfg1, view_win0, view_win1,
        view_win2);
    assign cfg_view = cfg_blocked ? 32'h0 : pick_view(cfg_idx, view_class, view_cfg1,
        view_win0, view_win1, view_win2);

    logic [31:0] next_loc_rdata;
    logic [31:0] next_cfg_rdata;
    logic next_cfg_refused;
    assign next_loc_rdata = loc_rd ? loc_view : 32'h0;
    assign next_cfg_rdata = cfg_rd ? cfg_view : 32'h0;
    assign next_cfg_refused = (cfg_rd || cfg_wr) && cfg_blocked;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            loc_rdata <= '0;
        end else begin
            loc_rdata <= next_loc_rdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_rdata <= '0;
        end else begin
            cfg_rdata <= next_cfg_rdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_refused <= 1'b0;
        end else begin
            cfg_refused <= next_cfg_refused;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Window hit decode
    logic claim_ok;
    logic [2:0] next_window_hit;
    logic [cfg_header_pkg::NUM_WINDOWS-1:0][31:0] win_word;
    logic [cfg_header_pkg::NUM_WINDOWS-1:0][31:0] win_mask;
    assign claim_ok = mem_valid && mem_space_enable;
    assign win_word = {view_win2, view_win1, view_win0};
    assign win_mask = {cfg_header_pkg::WIN2_MASK, cfg_header_pkg::WIN1_MASK,
        cfg_header_pkg::WIN0_MASK};

    // Base bits sit in place in each view, so one masked compare serves all
    for (genvar w = 0; w < cfg_header_pkg::NUM_WINDOWS; w++) begin : g_hit
        assign next_window_hit[w] = ((mem_addr ^ win_word[w]) & win_mask[w]) == 32'h0;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            window_hit <= '0;
        end else begin
            window_hit <= claim_ok ? next_window_hit : 3'b000;
        end
    end

endmodule
`default_nettype wire

// >>> logic/cfg_header_pkg.sv
// Constants for the PCI target configuration header bank
`default_nettype none
package cfg_header_pkg;
    // Local register map byte addresses
    localparam logic [15:0] ADDR_CLASS_REV = 16'hd008;
    localparam logic [15:0] ADDR_HDR_CFG1 = 16'hd00c;
    localparam logic [15:0] ADDR_WIN0_LOW = 16'hd010;
    localparam logic [15:0] ADDR_WIN0_HIGH = 16'hd014;
    localparam logic [15:0] ADDR_WIN1_LOW = 16'hd018;
    localparam logic [15:0] ADDR_WIN1_HIGH = 16'hd01c;
    localparam logic [15:0] ADDR_WIN2 = 16'hd020;
    // Configuration space offsets
    localparam logic [7:0] CFG_CLASS_REV = 8'h08;
    localparam logic [7:0] CFG_HDR_CFG1 = 8'h0c;
    localparam logic [7:0] CFG_WIN0_LOW = 8'h10;
    localparam logic [7:0] CFG_WIN0_HIGH = 8'h14;
    localparam logic [7:0] CFG_WIN1_LOW = 8'h18;
    localparam logic [7:0] CFG_WIN1_HIGH = 8'h1c;
    localparam logic [7:0] CFG_WIN2 = 8'h20;
    // Reset values
    localparam logic [23:0] DEVICE_CLASS_RST = 24'h060000;
    localparam logic [6:0] HEADER_LAYOUT_RST = 7'h00;
    localparam logic [7:0] SILICON_REV_RST = 8'h00;
    // Window base widths
    localparam int WIN0_BITS = 3;
    localparam int WIN1_BITS = 8;
    localparam int WIN2_BITS = 12;
    // Fixed low bits of window registers: prefetch, type, space indicator
    localparam logic [3:0] WIN_LOW_PREF = 4'h8;
    localparam logic [3:0] WIN_LOW_NOPREF = 4'h0;
    // Grant loss timer low bits forced to zero
    localparam logic [7:0] GRANT_TIMER_MASK = 8'hfc;
    // Field positions inside a register word
    localparam int WORD_MSB = 31;
    localparam int TIMER_MSB = 15;
    localparam int TIMER_LSB = 10;
    localparam int LINE_MSB = 7;
    localparam int LINE_LSB = 0;
    // Address bits compared for each window
    localparam int NUM_WINDOWS = 3;
    localparam logic [31:0] WIN0_MASK = 32'he0000000;
    localparam logic [31:0] WIN1_MASK = 32'hff000000;
    localparam logic [31:0] WIN2_MASK = 32'hfff00000;
endpackage
`default_nettype wire

// >>> testbench/cfg_header_props.sv
// Checker for the configuration header bank
`timescale 1ns/10ps
`default_nettype none
module cfg_header_props (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Watched ports
    input wire logic subordinate_mode,
    input wire logic mem_space_enable,
    input wire logic mem_valid,
    input wire logic cfg_rd,
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_offset,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_refused,
    input wire logic [2:0] window_hit,
    input wire logic [7:0] grant_loss_timer
);
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
chk_timer_low: assert property (grant_loss_timer[1:0] == 2'h0)
    else $error("timer low bits set");
chk_hit_gate: assert property (!(mem_valid && mem_space_enable) |=> window_hit == 3'h0)
    else $error("hit while disabled");
chk_refuse_id: assert property (cfg_rd && cfg_offset == 8'h08 && subordinate_mode |=>
    cfg_refused && cfg_rdata == 32'h0) else $error("id read not refused");
chk_no_refuse: assert property (!((cfg_rd || cfg_wr) && cfg_offset == 8'h08 &&
    subordinate_mode) |=> !cfg_refused) else $error("stray refusal");
chk_hdr_fixed: assert property (cfg_rd && cfg_offset == 8'h0c |=>
    cfg_rdata[31:23] == 9'h0 && cfg_rdata[9:8] == 2'h0) else $error("header bits");
chk_win0_fixed: assert property (cfg_rd && cfg_offset == 8'h10 |=>
    cfg_rdata[28:0] == 29'h8) else $error("window 0 low bits");
chk_win1_fixed: assert property (cfg_rd && cfg_offset == 8'h18 |=>
    cfg_rdata[23:0] == 24'h8) else $error("window 1 low bits");
chk_upper_zero: assert property (cfg_rd && (cfg_offset == 8'h14 || cfg_offset == 8'h1c)
    |=> cfg_rdata == 32'h0) else $error("upper base not zero");
chk_win2_fixed: assert property (cfg_rd && cfg_offset == 8'h20 |=>
    cfg_rdata[19:0] == 20'h0) else $error("window 2 low bits");
cover property (cfg_refused);
cover property (window_hit != 3'h0);
cover property (cfg_rd && cfg_offset == 8'h0c);
endmodule
bind cfg_header cfg_header_props u_cfg_header_props (.*);
`default_nettype wire

// >>> testbench/cfg_host_model.sv
// Configuration host model on the config port
`timescale 1ns/10ps
`default_nettype none
module cfg_host_model (
    // Clock
    input wire logic clk,
    // Config port
    output logic cfg_wr,
    output logic cfg_rd,
    output logic [7:0] cfg_offset,
    output logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_refused
);
initial {cfg_wr, cfg_rd, cfg_offset, cfg_wdata} = '0;
task wr(input logic [7:0] o, input logic [31:0] d);
    if (o == 8'h14 || o == 8'h1c) return;
    @(posedge clk) #1 {cfg_wr, cfg_offset, cfg_wdata} = {1'b1, o, d};
    @(posedge clk) #1 cfg_wr = 0;
    cfg_wdata = ~d;
endtask
task rd(input logic [7:0] o, output logic [31:0] d, output logic r);
    @(posedge clk) #1 {cfg_rd, cfg_offset} = {1'b1, o};
    @(posedge clk) #1 cfg_rd = 0;
    d = cfg_rdata;
    r = cfg_refused;
endtask
endmodule
`default_nettype wire

// >>> testbench/test_cfg_header.sv
// Bench for the configuration header bank
`timescale 1ns/10ps
`default_nettype none
module test_cfg_header;
logic clk = 0, rst_n = 0, subordinate_mode = 0, mem_space_enable = 0, eeprom_load = 0;
logic [23:0] eeprom_device_class = 24'h0c0330;
logic [7:0] eeprom_silicon_rev = 8'h5a;
logic [6:0] eeprom_header_layout = 7'h01;
logic loc_wr = 0, loc_rd = 0, mem_valid = 0, cfg_wr, cfg_rd, cfg_refused, rf;
logic [15:0] loc_addr = 16'h0;
logic [31:0] loc_wdata = 32'h0, mem_addr = 32'h0, loc_rdata, cfg_rdata, cfg_wdata, rd;
logic [7:0] cfg_offset, grant_loss_timer, line_size;
logic [2:0] window_hit;
int err_count = 0, checked = 0, cyc = 0;
always #2 clk = ~clk;
cfg_header u_cfg_header (.*);
cfg_host_model u_cfg_host_model (.*);
task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
        err_count++;
        $display("BAD %s exp %h got %h", n, e, s);
    end
endtask
task cr(input string n, input logic [7:0] o, input logic [31:0] e);
    u_cfg_host_model.rd(o, rd, rf);
    chk(n, e, rd);
endtask
task lw(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk) #1 {loc_wr, loc_addr, loc_wdata} = {1'b1, a, d};
    @(posedge clk) #1 loc_wr = 0;
endtask
task lr(input string n, input logic [15:0] a, input logic [31:0] e);
    @(posedge clk) #1 {loc_rd, loc_addr} = {1'b1, a};
    @(posedge clk) #1 loc_rd = 0;
    chk(n, e, loc_rdata);
endtask
task mc(input logic [31:0] a, input logic en, input logic [2:0] e);
    @(posedge clk) #1 {mem_valid, mem_space_enable, mem_addr} = {1'b1, en, a};
    @(posedge clk) #1 mem_valid = 0;
    chk("window_hit", {29'h0, e}, {29'h0, window_hit});
endtask
task t_reset;
    cr("class_rev", 8'h08, {cfg_header_pkg::DEVICE_CLASS_RST, 8'h00});
    cr("hdr_cfg1", 8'h0c, 32'h0);
    cr("win0", 8'h10, 32'h8);
    cr("win1", 8'h18, 32'h8);
    cr("win2", 8'h20, 32'h0);
endtask
task t_regs;
    u_cfg_host_model.wr(8'h08, 32'hffffffff);
    cr("class_rev", 8'h08, 32'h06000000);
    u_cfg_host_model.wr(8'h0c, 32'hffffffff);
    cr("hdr_cfg1", 8'h0c, 32'h0000fcff);
    chk("timers", 32'hfcff, {16'h0, grant_loss_timer, line_size});
    u_cfg_host_model.wr(8'h10, 32'hffffffff);
    cr("win0", 8'h10, 32'he0000008);
    u_cfg_host_model.wr(8'h18, 32'hffffffff);
    cr("win1", 8'h18, 32'hff000008);
    u_cfg_host_model.wr(8'h20, 32'hffffffff);
    lr("win2", 16'hd020, 32'hfff00000);
    cr("upper1", 8'h1c, 32'h0);
    lr("unmapped", 16'hd030, 32'h0);
endtask
task t_hits;
    lw(16'hd010, 32'h20000000);
    lw(16'hd018, 32'h05000000);
    lw(16'hd020, 32'h0a300000);
    mc(32'h05123456, 1'b1, 3'h2);
    mc(32'h2abcdef0, 1'b1, 3'h1);
    mc(32'h0a3fffff, 1'b1, 3'h4);
    mc(32'h05123456, 1'b0, 3'h0);
endtask
task t_eeprom;
    @(posedge clk) #1 eeprom_load = 1;
    @(posedge clk) #1 eeprom_load = 0;
    cr("class_rev", 8'h08, 32'h0c03305a);
    cr("hdr_cfg1", 8'h0c, 32'h0001fcff);
endtask
task t_sub;
    subordinate_mode = 1;
    cr("refused_data", 8'h08, 32'h0);
    chk("refused", 32'h1, {31'h0, rf});
    lr("local_id", 16'hd008, 32'h0c03305a);
    subordinate_mode = 0;
endtask
task t_rerun;
    @(posedge clk) #1 rst_n = 0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1;
    cr("class_rev", 8'h08, {cfg_header_pkg::DEVICE_CLASS_RST, 8'h00});
    cr("hdr_cfg1", 8'h0c, 32'h0);
    lr("win1", 16'hd018, 32'h8);
    mc(32'h0, 1'b1, 3'h7);
endtask
task end_sim;
    if (err_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
endtask
always @(posedge clk) if (++cyc == 5000) begin
    err_count++;
    end_sim();
end
initial begin
    repeat (10) @(posedge clk);
    #1 rst_n = 1;
    t_reset();
    t_regs();
    t_hits();
    t_eeprom();
    t_sub();
    t_rerun();
    end_sim();
end
endmodule
`default_nettype wire
